// ===== inc/vbl_pkg.sv
// shared constants and types for the link mode control block
package vbl_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_MHZ = 20;
  // idle bus time required before rejoining, in microseconds
  localparam int IDLE_TIME_US = 300;
  localparam int IDLE_CYC_DEF = IDLE_TIME_US * CLK_MHZ;
  // clock stabilisation time after stop wake, in cycles
  localparam int STAB_CYC_DEF = 64;
  // ==========================================================
  // bus levels
  localparam logic BUS_PASSIVE = 1'h0;
  localparam logic BUS_ACTIVE = 1'h1;
  // ==========================================================
  // operating modes
  typedef enum logic [1:0] {
    MODE_RESET,
    MODE_RUN,
    MODE_WAIT,
    MODE_STOP
  } vbl_mode_t;
endpackage

// ===== hdl/vbl_mode_ctrl.sv
// operating mode and loopback control for the vehicle bus link controller
`timescale 1ns/10ps
`default_nettype none
module vbl_mode_ctrl #(
  parameter int IDLE_CYC = vbl_pkg::IDLE_CYC_DEF,
  parameter int STAB_CYC = vbl_pkg::STAB_CYC_DEF
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic mcu_reset_active,
  input wire logic cpu_wait_exec,
  input wire logic cpu_stop_exec,
  input wire logic cpu_running,
  input wire logic wait_stops_clocks_select,
  input wire logic digital_loopback_en,
  input wire logic analog_loopback_en,
  input wire logic eof_valid,
  input wire logic irq_ack,
  input wire logic digital_transmit_out,
  output logic digital_receive_in,
  input wire logic phy_rx_pin,
  output logic phy_tx_pin,
  output logic phy_low_power,
  output logic clocks_run,
  output logic wake_irq,
  output logic rx_reliable,
  output logic comm_enable,
  output vbl_pkg::vbl_mode_t mode
);

  localparam int IW = $clog2(IDLE_CYC + 1);
  localparam int SW = $clog2(STAB_CYC + 1);
  localparam logic [IW-1:0] IDLE_MAX = IW'(IDLE_CYC);
  localparam logic [SW-1:0] STAB_MAX = SW'(STAB_CYC);

  // ==========================================================
  // state
  vbl_pkg::vbl_mode_t mode_ff, nxt_mode;
  logic rx_s1_ff, nxt_rx_s1;
  logic rx_s2_ff, nxt_rx_s2;
  logic rx_prev_ff, nxt_rx_prev;
  logic irq_ff, nxt_irq;
  logic tx_ff, nxt_tx;
  logic crx_ff, nxt_crx;
  logic alb_prev_ff, nxt_alb_prev;
  logic hold_ff, nxt_hold;
  logic [IW-1:0] idle_ff, nxt_idle;
  logic [SW-1:0] stab_ff, nxt_stab;
  logic act_edge;
  logic wake;

  // ==========================================================
  // next state
  always_comb begin
    nxt_rx_s1 = phy_rx_pin;
    nxt_rx_s2 = rx_s1_ff;
    nxt_rx_prev = rx_s2_ff;
    act_edge = (rx_s2_ff == vbl_pkg::BUS_ACTIVE) && (rx_prev_ff == vbl_pkg::BUS_PASSIVE);
    wake = 1'h0;
    nxt_mode = mode_ff;
    nxt_stab = stab_ff;
    case (mode_ff)
      vbl_pkg::MODE_RESET: begin
        nxt_mode = vbl_pkg::MODE_RUN;
      end
      vbl_pkg::MODE_RUN: begin
        // stop wins when both instructions seem to arrive together
        if (cpu_stop_exec || (cpu_wait_exec && wait_stops_clocks_select)) begin
          nxt_mode = vbl_pkg::MODE_STOP;
        end else if (cpu_wait_exec) begin
          nxt_mode = vbl_pkg::MODE_WAIT;
        end
        if (stab_ff != STAB_MAX) begin
          nxt_stab = stab_ff + SW'(1);
        end
      end
      vbl_pkg::MODE_WAIT: begin
        if (act_edge || eof_valid) begin
          wake = 1'h1;
          nxt_mode = vbl_pkg::MODE_RUN;
        end
      end
      vbl_pkg::MODE_STOP: begin
        if (act_edge) begin
          wake = 1'h1;
          nxt_stab = '0;
          nxt_mode = vbl_pkg::MODE_RUN;
        end
      end
      default: begin
        nxt_mode = vbl_pkg::MODE_RESET;
      end
    endcase
    if (mcu_reset_active) begin
      nxt_mode = vbl_pkg::MODE_RESET;
    end
    // a wake in the same cycle as the ack keeps the request
    nxt_irq = wake || (irq_ff && !irq_ack);
    // joining tx to rx keeps the bus passive while self-testing
    if (digital_loopback_en) begin
      nxt_tx = vbl_pkg::BUS_PASSIVE;
      nxt_crx = digital_transmit_out;
    end else begin
      nxt_tx = digital_transmit_out;
      nxt_crx = rx_s2_ff;
    end
    nxt_alb_prev = analog_loopback_en;
    if (rx_s2_ff == vbl_pkg::BUS_PASSIVE) begin
      nxt_idle = (idle_ff == IDLE_MAX) ? idle_ff : idle_ff + IW'(1);
    end else begin
      nxt_idle = '0;
    end
    nxt_hold = hold_ff;
    if (idle_ff == IDLE_MAX) begin
      nxt_hold = 1'h0;
    end
    // a fresh exit always restarts the wait, even over an idle bus
    if (alb_prev_ff && !analog_loopback_en) begin
      nxt_hold = 1'h1;
      // the idle count starts over, so an already idle bus is seen afresh
      nxt_idle = '0;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_ff <= vbl_pkg::MODE_RESET;
      rx_s1_ff <= vbl_pkg::BUS_PASSIVE;
      rx_s2_ff <= vbl_pkg::BUS_PASSIVE;
      rx_prev_ff <= vbl_pkg::BUS_PASSIVE;
      irq_ff <= 1'h0;
      tx_ff <= vbl_pkg::BUS_PASSIVE;
      crx_ff <= vbl_pkg::BUS_PASSIVE;
      alb_prev_ff <= 1'h0;
      hold_ff <= 1'h0;
      idle_ff <= '0;
      stab_ff <= '0;
    end else begin
      mode_ff <= nxt_mode;
      rx_s1_ff <= nxt_rx_s1;
      rx_s2_ff <= nxt_rx_s2;
      rx_prev_ff <= nxt_rx_prev;
      irq_ff <= nxt_irq;
      tx_ff <= nxt_tx;
      crx_ff <= nxt_crx;
      alb_prev_ff <= nxt_alb_prev;
      hold_ff <= nxt_hold;
      idle_ff <= nxt_idle;
      stab_ff <= nxt_stab;
    end
  end

  // ==========================================================
  // outputs
  assign mode = mode_ff;
  assign wake_irq = irq_ff;
  assign phy_tx_pin = tx_ff;
  assign digital_receive_in = crx_ff;
  assign clocks_run = (mode_ff != vbl_pkg::MODE_STOP);
  assign phy_low_power = (mode_ff == vbl_pkg::MODE_STOP);
  // reception trusted only with settled clocks and a running cpu
  assign rx_reliable = (mode_ff == vbl_pkg::MODE_RUN) && (stab_ff == STAB_MAX) && cpu_running;
  // software is trusted to drain transmissions before wait or stop
  assign comm_enable = (mode_ff == vbl_pkg::MODE_RUN) && !hold_ff;

  // ==========================================================
  // checks
  chk_reset_exit: assert property (@(posedge sys_clk) disable iff (rst)
    (mode_ff == vbl_pkg::MODE_RESET) && !mcu_reset_active |=> mode_ff == vbl_pkg::MODE_RUN)
    else $error("reset mode not left for run");
  chk_reset_hold: assert property (@(posedge sys_clk) disable iff (rst)
    mcu_reset_active |=> mode_ff == vbl_pkg::MODE_RESET)
    else $error("run entered while a reset source is active");
  chk_wait_wake: assert property (@(posedge sys_clk) disable iff (rst)
    (mode_ff == vbl_pkg::MODE_WAIT) && act_edge && !mcu_reset_active
    |=> (mode_ff == vbl_pkg::MODE_RUN) && wake_irq)
    else $error("bus activity did not wake from wait");
  chk_eof_wake: assert property (@(posedge sys_clk) disable iff (rst)
    (mode_ff == vbl_pkg::MODE_WAIT) && eof_valid && !mcu_reset_active
    |=> (mode_ff == vbl_pkg::MODE_RUN) && wake_irq)
    else $error("end of frame did not wake from wait");
  chk_stop_wake: assert property (@(posedge sys_clk) disable iff (rst)
    (mode_ff == vbl_pkg::MODE_STOP) && act_edge && !mcu_reset_active
    |=> clocks_run && wake_irq && !rx_reliable)
    else $error("stop wake wrong");
  chk_wait_entry: assert property (@(posedge sys_clk) disable iff (rst)
    (mode_ff == vbl_pkg::MODE_RUN) && cpu_wait_exec && !cpu_stop_exec
    && !wait_stops_clocks_select && !mcu_reset_active
    |=> (mode_ff == vbl_pkg::MODE_WAIT) && clocks_run)
    else $error("wait mode not entered");
  chk_stop_entry: assert property (@(posedge sys_clk) disable iff (rst)
    (mode_ff == vbl_pkg::MODE_RUN) && !mcu_reset_active
    && (cpu_stop_exec || (cpu_wait_exec && wait_stops_clocks_select))
    |=> (mode_ff == vbl_pkg::MODE_STOP) && !clocks_run && phy_low_power)
    else $error("stop mode not entered");
  chk_irq_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    wake_irq && !irq_ack |=> wake_irq)
    else $error("wake request lost before ack");
  chk_dig_loop: assert property (@(posedge sys_clk) disable iff (rst)
    digital_loopback_en |=> (digital_receive_in == $past(digital_transmit_out))
    && (phy_tx_pin == vbl_pkg::BUS_PASSIVE))
    else $error("digital loopback path wrong");
  chk_ana_pass: assert property (@(posedge sys_clk) disable iff (rst)
    !digital_loopback_en |=> (phy_tx_pin == $past(digital_transmit_out))
    && (digital_receive_in == $past(rx_s2_ff)))
    else $error("normal path altered");
  chk_idle_wait: assert property (@(posedge sys_clk) disable iff (rst)
    alb_prev_ff && !analog_loopback_en |=> !comm_enable ##1 !comm_enable)
    else $error("rejoined before an idle bus");

  // ==========================================================
  // refused requests and mode holding
  chk_wait_stays: assert property (@(posedge sys_clk) disable iff (rst)
    (mode_ff == vbl_pkg::MODE_WAIT) && !act_edge && !eof_valid && !mcu_reset_active
    |=> (mode_ff == vbl_pkg::MODE_WAIT) && clocks_run)
    else $error("wait mode left without a wake");
  chk_stop_stays: assert property (@(posedge sys_clk) disable iff (rst)
    (mode_ff == vbl_pkg::MODE_STOP) && !act_edge && !mcu_reset_active
    |=> (mode_ff == vbl_pkg::MODE_STOP) && !clocks_run)
    else $error("stop mode left without bus activity");
  chk_stop_no_eof: assert property (@(posedge sys_clk) disable iff (rst)
    (mode_ff == vbl_pkg::MODE_STOP) && eof_valid && !act_edge && !mcu_reset_active
    |=> (mode_ff == vbl_pkg::MODE_STOP))
    else $error("end of frame woke stop mode");
  chk_run_stays: assert property (@(posedge sys_clk) disable iff (rst)
    (mode_ff == vbl_pkg::MODE_RUN) && !cpu_wait_exec && !cpu_stop_exec
    && !mcu_reset_active |=> (mode_ff == vbl_pkg::MODE_RUN))
    else $error("run mode left without an instruction");
  chk_stop_to_run: assert property (@(posedge sys_clk) disable iff (rst)
    (mode_ff == vbl_pkg::MODE_STOP) && act_edge && !mcu_reset_active
    |=> (mode_ff == vbl_pkg::MODE_RUN) && (stab_ff == '0))
    else $error("stop wake did not return to run");
  chk_wait_from_run: assert property (@(posedge sys_clk) disable iff (rst)
    (mode_ff != vbl_pkg::MODE_RUN) && (mode_ff != vbl_pkg::MODE_WAIT)
    && !mcu_reset_active |=> (mode_ff != vbl_pkg::MODE_WAIT))
    else $error("wait mode entered from outside run");

  // ==========================================================
  // wake request
  chk_irq_clear: assert property (@(posedge sys_clk) disable iff (rst)
    wake_irq && irq_ack && !wake
    |=> !wake_irq)
    else $error("wake request not cleared by ack");
  chk_irq_source: assert property (@(posedge sys_clk) disable iff (rst)
    !wake_irq && !wake
    |=> !wake_irq)
    else $error("wake request raised without a wake event");
  chk_irq_wins: assert property (@(posedge sys_clk) disable iff (rst)
    wake && irq_ack
    |=> wake_irq)
    else $error("wake lost to a same cycle ack");

  // ==========================================================
  // outputs per mode
  chk_reset_outs: assert property (@(posedge sys_clk) disable iff (rst)
    (mode_ff == vbl_pkg::MODE_RESET)
    |-> clocks_run && !phy_low_power && !rx_reliable && !comm_enable)
    else $error("reset mode outputs wrong");
  chk_rel_mode: assert property (@(posedge sys_clk) disable iff (rst)
    (mode_ff != vbl_pkg::MODE_RUN) || !cpu_running
    |-> !rx_reliable)
    else $error("reception trusted outside run");
  chk_comm_mode: assert property (@(posedge sys_clk) disable iff (rst)
    (mode_ff != vbl_pkg::MODE_RUN)
    |-> !comm_enable)
    else $error("communication enabled outside run");
  chk_rel_settle: assert property (@(posedge sys_clk) disable iff (rst)
    (mode_ff == vbl_pkg::MODE_RUN) && (stab_ff != STAB_MAX)
    |-> !rx_reliable)
    else $error("reception trusted before clocks settled");

  // ==========================================================
  // idle wait after analog loopback
  chk_hold_exit: assert property (@(posedge sys_clk) disable iff (rst)
    alb_prev_ff && !analog_loopback_en
    |=> hold_ff && (idle_ff == '0))
    else $error("loopback exit did not restart the idle wait");
  chk_hold_release: assert property (@(posedge sys_clk) disable iff (rst)
    hold_ff && (idle_ff == IDLE_MAX) && !(alb_prev_ff && !analog_loopback_en)
    |=> !hold_ff)
    else $error("hold kept over an idle bus");
  chk_hold_busy: assert property (@(posedge sys_clk) disable iff (rst)
    hold_ff && (rx_s2_ff == vbl_pkg::BUS_ACTIVE)
    |=> hold_ff && (idle_ff == '0))
    else $error("hold released over an active bus");
  chk_alb_pass: assert property (@(posedge sys_clk) disable iff (rst)
    analog_loopback_en && !digital_loopback_en
    |=> (phy_tx_pin == $past(digital_transmit_out)))
    else $error("analog loopback altered transmit path");

endmodule
`default_nettype wire

// ===== bench/vbl_xcvr_model.sv
// transceiver model for the far side of the link mode control block
`timescale 1ns/10ps
`default_nettype none
module vbl_xcvr_model (
  input wire logic tx_pin,
  input wire logic other_drive,
  output logic rx_pin
);
  // ==========================================
  // wired bus
  // passive level is the pulled level, so a released bus never holds a stale value
  assign rx_pin = tx_pin | other_drive;
endmodule
`default_nettype wire

// ===== bench/vbl_mode_ctrl_tb_top.sv
// testbench for the link mode control block
`timescale 1ns/10ps
`default_nettype none
module vbl_mode_ctrl_tb_top;
  localparam int IDLE = 20;
  localparam int STAB = 4;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic mrst = 1'h1;
  logic wt = 1'h0, sp = 1'h0, cpu = 1'h1, sel = 1'h0, dlb = 1'h0, alb = 1'h0;
  logic eof = 1'h0, ack = 1'h0, tx = 1'h0, other = 1'h0;
  logic rxd, rx_pin, tx_pin, lp, crun, irq, rel, comm;
  vbl_pkg::vbl_mode_t mode;
  int miscompares = 0;
  int samples_checked = 0;
  always #25 sys_clk = ~sys_clk;
  // ==========================================
  // design and far side
  vbl_mode_ctrl #(.IDLE_CYC(IDLE), .STAB_CYC(STAB)) vbl_mode_ctrl_i (.sys_clk(sys_clk),
    .rst(rst), .mcu_reset_active(mrst), .cpu_wait_exec(wt), .cpu_stop_exec(sp),
    .cpu_running(cpu), .wait_stops_clocks_select(sel), .digital_loopback_en(dlb),
    .analog_loopback_en(alb), .eof_valid(eof), .irq_ack(ack), .digital_transmit_out(tx),
    .digital_receive_in(rxd), .phy_rx_pin(rx_pin), .phy_tx_pin(tx_pin), .phy_low_power(lp),
    .clocks_run(crun), .wake_irq(irq), .rx_reliable(rel), .comm_enable(comm), .mode(mode));
  vbl_xcvr_model vbl_xcvr_model_i (.tx_pin(tx_pin), .other_drive(other), .rx_pin(rx_pin));
  // ==========================================
  // helpers
  task automatic chk(input logic [2:0] seen, input logic [2:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // bounded wait; running out counts as a mismatch and ends the run
  task automatic await(input logic [1:0] m, input int n);
    for (int i = 0; i < n && mode !== m; i++) tick(1);
    chk(mode, m);
    if (mode !== m) results();
  endtask
  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic wait_wake(input logic by_eof);
    @(posedge sys_clk);
    tx <= 1'h0;
    wt <= 1'h1;
    @(posedge sys_clk);
    wt <= 1'h0;
    await(vbl_pkg::MODE_WAIT, 3);
    chk({crun, lp}, 3'h2);
    @(posedge sys_clk);
    eof <= by_eof;
    other <= ~by_eof;
    @(posedge sys_clk);
    eof <= 1'h0;
    await(vbl_pkg::MODE_RUN, 6);
    chk(irq, 1'h1);
    @(posedge sys_clk);
    ack <= 1'h1;
    other <= 1'h0;
    @(posedge sys_clk);
    ack <= 1'h0;
    tick(2);
    chk(irq, 1'h0);
  endtask
  task automatic stop_wake(input logic via_wait);
    @(posedge sys_clk);
    sel <= via_wait;
    wt <= via_wait;
    sp <= ~via_wait;
    @(posedge sys_clk);
    wt <= 1'h0;
    sp <= 1'h0;
    await(vbl_pkg::MODE_STOP, 3);
    chk({crun, lp}, 3'h1);
    @(posedge sys_clk);
    other <= 1'h1;
    await(vbl_pkg::MODE_RUN, 6);
    chk({crun, irq, lp}, 3'h6);
    chk(rel, 1'h0);
    @(posedge sys_clk);
    ack <= 1'h1;
    other <= 1'h0;
    sel <= 1'h0;
    @(posedge sys_clk);
    ack <= 1'h0;
    tick(STAB + 2);
    chk(rel, 1'h1);
  endtask
  task automatic refused;
    @(posedge sys_clk);
    eof <= 1'h1;
    @(posedge sys_clk);
    eof <= 1'h0;
    tick(2);
    chk(mode, vbl_pkg::MODE_RUN);
    chk(irq, 1'h0);
    @(posedge sys_clk);
    cpu <= 1'h0;
    tick(1);
    chk(rel, 1'h0);
    @(posedge sys_clk);
    cpu <= 1'h1;
    mrst <= 1'h1;
    tick(2);
    chk(mode, vbl_pkg::MODE_RESET);
    chk(comm, 1'h0);
    @(posedge sys_clk);
    mrst <= 1'h0;
    await(vbl_pkg::MODE_RUN, 3);
  endtask
  task automatic dig_loop;
    @(posedge sys_clk);
    dlb <= 1'h1;
    tx <= 1'h1;
    tick(2);
    chk({rxd, tx_pin}, 3'h2);
    @(posedge sys_clk);
    tx <= 1'h0;
    tick(2);
    chk(rxd, 1'h0);
    @(posedge sys_clk);
    dlb <= 1'h0;
  endtask
  task automatic ana_loop;
    @(posedge sys_clk);
    alb <= 1'h1;
    tx <= 1'h1;
    tick(5);
    chk({tx_pin, rxd, comm}, 3'h7);
    @(posedge sys_clk);
    tx <= 1'h0;
    tick(5);
    @(posedge sys_clk);
    alb <= 1'h0;
    tick(3);
    chk(comm, 1'h0);
    tick(IDLE - 4);
    chk(comm, 1'h0);
    tick(10);
    chk(comm, 1'h1);
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'h0;
    tick(3);
    chk(mode, vbl_pkg::MODE_RESET);
    @(posedge sys_clk);
    mrst <= 1'h0;
    await(vbl_pkg::MODE_RUN, 3);
    wait_wake(1'h0);
    wait_wake(1'h1);
    stop_wake(1'h0);
    stop_wake(1'h1);
    refused();
    dig_loop();
    ana_loop();
    results();
  end
endmodule
`default_nettype wire
